// ===== inc/dphio_regs.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * dual port handshake io block.
 * assumes a 4-bit register select and an 8-bit data bus on the host side.
 */
// Summary of operation
// - direction bit 0 makes a line input, undriven; 1 makes it output.
// - output line drives high for output bit 1, low for bit 0.
// - output bits of input lines are stored; they appear once direction flips.
// - port read returns the input register; transparent while latching is off.
// - port A latching captures port A pins on line one's active edge.
// - reading latched port A data makes it transparent until the next edge.
// - port A read shows real pin level for output lines.
// - port B read shows stored output value for output lines.
// - port B latching captures input pins on its line one's active edge.
// - read handshake on port A: data ready on line one sets a flag.
// - port A line two drives data taken low on access, high on next ready.
// - port B handshakes writes only; port A handshakes reads and writes.
// - line two is the write data ready output, level or pulse mode.
// - data taken on line one sets a flag and releases data ready.
// - control register: bits 7-5, 4, 3-1 and 0 hold the four line fields.
// - line two field codes 000..111 select eight input or output modes.
// - line one field bit: 0 selects negative edge, 1 positive edge.
// - independent input modes: port data access leaves the line two flag.
`ifndef DPHIO_REGS_SVH
`define DPHIO_REGS_SVH

`define DPHIO_OFF_PORT_B 4'h0
`define DPHIO_OFF_PORT_A 4'h1
`define DPHIO_OFF_DIR_B 4'h2
`define DPHIO_OFF_DIR_A 4'h3
`define DPHIO_OFF_CTRL 4'hc
`define DPHIO_OFF_PORT_A_NOHS 4'hf

`define DPHIO_CTRL_A1_BIT 0
`define DPHIO_CTRL_A2_LSB 1
`define DPHIO_CTRL_A2_MSB 3
`define DPHIO_CTRL_B1_BIT 4
`define DPHIO_CTRL_B2_LSB 5
`define DPHIO_CTRL_B2_MSB 7

`define DPHIO_RST_DATA 8'h00
`define DPHIO_RST_DIR 8'h00
`define DPHIO_RST_CTRL 8'h00

`define DPHIO_PULSE_CYCLES 1

`endif

// ===== inc/dphio_pkg.sv
/*
 * types of the dual port handshake io block.
 * assumes dphio_regs.svh supplies the numeric constants.
 */
package dphio_pkg;

    typedef enum logic [2:0] {
        DPHIO_IN_NEG = 3'h0,
        DPHIO_IND_NEG = 3'h1,
        DPHIO_IN_POS = 3'h2,
        DPHIO_IND_POS = 3'h3,
        DPHIO_HANDSHAKE = 3'h4,
        DPHIO_PULSE = 3'h5,
        DPHIO_LOW = 3'h6,
        DPHIO_HIGH = 3'h7
    } dphio_line_mode_t;

endpackage

// ===== design/dphio_top.sv
/*
 * dual port handshake io: two 8-bit ports with direction and output
 * registers, input latching, and four handshake control lines.
 * assumes all inputs are synchronous to clk, one register access per cycle
 * while bus_sel is high, and that latching enables and flag clears come
 * from the auxiliary control and interrupt flag logic outside.
 */
`timescale 1ns/1ns
`include "dphio_regs.svh"

module dphio_top
    import dphio_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic [PORT_W-1:0] port_a_lines_in,
    output logic [PORT_W-1:0] port_a_lines_out,
    output logic [PORT_W-1:0] port_a_lines_oe,
    input wire logic [PORT_W-1:0] port_b_lines_in,
    output logic [PORT_W-1:0] port_b_lines_out,
    output logic [PORT_W-1:0] port_b_lines_oe,
    input wire logic port_a_ctrl_line_one,
    input wire logic port_a_ctrl_line_two_in,
    output logic port_a_ctrl_line_two_out,
    output logic port_a_ctrl_line_two_oe,
    input wire logic port_b_ctrl_line_one,
    input wire logic port_b_ctrl_line_two_in,
    output logic port_b_ctrl_line_two_out,
    output logic port_b_ctrl_line_two_oe,
    input wire logic latch_en_a,
    input wire logic latch_en_b,
    input wire logic [3:0] flag_clr,
    output logic [3:0] line_flags
);

    // the register file is 8 bits wide, so a port cannot be any wider
    if (PORT_W < 1 || PORT_W > 8) begin : g_bad_width
        $error("dphio_top: PORT_W must lie in 1..8");
    end

    // the pulse flop below holds a line two output low for one cycle only
    if (`DPHIO_PULSE_CYCLES != 1) begin : g_bad_pulse
        $error("dphio_top: only a one cycle pulse is supported");
    end

    // line two decode reads three bit mode codes inside the 8-bit register
    if (`DPHIO_CTRL_A2_MSB - `DPHIO_CTRL_A2_LSB != 2 ||
            `DPHIO_CTRL_B2_MSB - `DPHIO_CTRL_B2_LSB != 2 || `DPHIO_CTRL_B2_MSB > 7) begin : g_bad_field
        $error("dphio_top: line two fields must be three bits wide");
    end

    // the no-handshake alias must not shadow port A or the control register
    if (`DPHIO_OFF_PORT_A_NOHS == `DPHIO_OFF_PORT_A ||
            `DPHIO_OFF_PORT_A_NOHS == `DPHIO_OFF_CTRL) begin : g_bad_alias
        $error("dphio_top: port A alias offset collides");
    end

    function automatic logic edge_hit(input logic prev, input logic cur, input logic pos);
        edge_hit = pos ? (!prev && cur) : (prev && !cur);
    endfunction

    function automatic logic [7:0] widen(input logic [PORT_W-1:0] v);
        logic [7:0] w;
        w = 8'h00;
        w[PORT_W-1:0] = v;
        widen = w;
    endfunction

    // registers
    logic [PORT_W-1:0] out_a_r;
    logic [PORT_W-1:0] out_b_r;
    logic [PORT_W-1:0] dir_a_r;
    logic [PORT_W-1:0] dir_b_r;
    logic [7:0] ctrl_r;
    logic [PORT_W-1:0] in_a_latch_r;
    logic [PORT_W-1:0] in_b_latch_r;
    logic in_a_held_r;
    logic a1_prev_r;
    logic a2_prev_r;
    logic b1_prev_r;
    logic b2_prev_r;
    logic [3:0] flags_r;
    logic a2_out_r;
    logic b2_out_r;
    logic a2_pulse_r;
    logic b2_pulse_r;
    logic [7:0] rdata_r;

    logic [3:0] flags_nxt;
    logic a2_out_nxt;
    logic b2_out_nxt;
    logic [7:0] rdata_nxt;

    // access decode
    wire logic acc_b = bus_sel && (bus_addr == `DPHIO_OFF_PORT_B);
    wire logic acc_a_hs = bus_sel && (bus_addr == `DPHIO_OFF_PORT_A);
    wire logic acc_a_nohs = bus_sel && (bus_addr == `DPHIO_OFF_PORT_A_NOHS);
    wire logic acc_a = acc_a_hs || acc_a_nohs;
    wire logic wr_b = acc_b && bus_wr;
    wire logic wr_a = acc_a && bus_wr;
    wire logic rd_a = acc_a && !bus_wr;
    wire logic wr_dir_b = bus_sel && bus_wr && (bus_addr == `DPHIO_OFF_DIR_B);
    wire logic wr_dir_a = bus_sel && bus_wr && (bus_addr == `DPHIO_OFF_DIR_A);
    wire logic wr_ctrl = bus_sel && bus_wr && (bus_addr == `DPHIO_OFF_CTRL);
    wire logic rd_any = bus_sel && !bus_wr;

    // control field split
    wire logic a1_pos = ctrl_r[`DPHIO_CTRL_A1_BIT];
    wire logic b1_pos = ctrl_r[`DPHIO_CTRL_B1_BIT];
    wire dphio_line_mode_t a2_mode =
        dphio_line_mode_t'(ctrl_r[`DPHIO_CTRL_A2_MSB:`DPHIO_CTRL_A2_LSB]);
    wire dphio_line_mode_t b2_mode =
        dphio_line_mode_t'(ctrl_r[`DPHIO_CTRL_B2_MSB:`DPHIO_CTRL_B2_LSB]);

    // line two input modes have the top code bit clear
    wire logic a2_is_out = a2_mode[2];
    wire logic b2_is_out = b2_mode[2];
    wire logic a2_in_pos = a2_mode[1];
    wire logic b2_in_pos = b2_mode[1];
    wire logic a2_indep = !a2_is_out && a2_mode[0];
    wire logic b2_indep = !b2_is_out && b2_mode[0];

    // edge detection on the sampled control lines
    wire logic a1_edge = edge_hit(a1_prev_r, port_a_ctrl_line_one, a1_pos);
    wire logic b1_edge = edge_hit(b1_prev_r, port_b_ctrl_line_one, b1_pos);
    wire logic a2_edge = !a2_is_out && edge_hit(a2_prev_r, port_a_ctrl_line_two_in, a2_in_pos);
    wire logic b2_edge = !b2_is_out && edge_hit(b2_prev_r, port_b_ctrl_line_two_in, b2_in_pos);

    // flag clears from port data access; the no-handshake alias of port A
    // deliberately leaves the flags and the line two output alone
    wire logic clr_a1 = acc_a_hs || flag_clr[0];
    wire logic clr_a2 = (acc_a_hs && !a2_indep) || flag_clr[1];
    wire logic clr_b1 = acc_b || flag_clr[2];
    wire logic clr_b2 = (acc_b && !b2_indep) || flag_clr[3];

    // read path
    wire logic [PORT_W-1:0] in_a_view = in_a_held_r ? in_a_latch_r : port_a_lines_in;
    // port A shows the pin, so heavy loading on an output line reads back wrong
    wire logic [PORT_W-1:0] rd_a_val = latch_en_a ? in_a_view : port_a_lines_in;
    wire logic [PORT_W-1:0] in_b_view = latch_en_b ? in_b_latch_r : port_b_lines_in;
    wire logic [PORT_W-1:0] rd_b_val = (dir_b_r & out_b_r) | (~dir_b_r & in_b_view);

    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_any) begin
            if (bus_addr == `DPHIO_OFF_PORT_B) begin
                rdata_nxt = widen(rd_b_val);
            end else if (bus_addr == `DPHIO_OFF_PORT_A || bus_addr == `DPHIO_OFF_PORT_A_NOHS) begin
                rdata_nxt = widen(rd_a_val);
            end else if (bus_addr == `DPHIO_OFF_DIR_B) begin
                rdata_nxt = widen(dir_b_r);
            end else if (bus_addr == `DPHIO_OFF_DIR_A) begin
                rdata_nxt = widen(dir_a_r);
            end else if (bus_addr == `DPHIO_OFF_CTRL) begin
                rdata_nxt = ctrl_r;
            end else begin
                // timers, shift register and interrupt registers live elsewhere
                rdata_nxt = 8'h00;
            end
        end
    end

    // flags: a set in the same cycle as its clear wins
    always_comb begin
        flags_nxt = flags_r;
        if (clr_a1) begin
            flags_nxt[0] = 1'b0;
        end
        if (a1_edge) begin
            flags_nxt[0] = 1'b1;
        end
        if (clr_a2) begin
            flags_nxt[1] = 1'b0;
        end
        if (a2_edge) begin
            flags_nxt[1] = 1'b1;
        end
        if (clr_b1) begin
            flags_nxt[2] = 1'b0;
        end
        if (b1_edge) begin
            flags_nxt[2] = 1'b1;
        end
        if (clr_b2) begin
            flags_nxt[3] = 1'b0;
        end
        if (b2_edge) begin
            flags_nxt[3] = 1'b1;
        end
    end

    // port A line two: read and write handshake; an access beats a
    // simultaneous data edge so that the access is never lost
    always_comb begin
        a2_out_nxt = 1'b1;
        case (a2_mode)
            DPHIO_HANDSHAKE: begin
                a2_out_nxt = a2_out_r;
                if (a1_edge) begin
                    a2_out_nxt = 1'b1;
                end
                if (acc_a_hs) begin
                    a2_out_nxt = 1'b0;
                end
            end
            DPHIO_PULSE: begin
                a2_out_nxt = !a2_pulse_r;
            end
            DPHIO_LOW: begin
                a2_out_nxt = 1'b0;
            end
            DPHIO_HIGH: begin
                a2_out_nxt = 1'b1;
            end
            default: begin
                a2_out_nxt = 1'b1;
            end
        endcase
    end

    // port B line two: write handshake only
    always_comb begin
        b2_out_nxt = 1'b1;
        case (b2_mode)
            DPHIO_HANDSHAKE: begin
                b2_out_nxt = b2_out_r;
                if (b1_edge) begin
                    b2_out_nxt = 1'b1;
                end
                if (wr_b) begin
                    b2_out_nxt = 1'b0;
                end
            end
            DPHIO_PULSE: begin
                b2_out_nxt = !b2_pulse_r;
            end
            DPHIO_LOW: begin
                b2_out_nxt = 1'b0;
            end
            DPHIO_HIGH: begin
                b2_out_nxt = 1'b1;
            end
            default: begin
                b2_out_nxt = 1'b1;
            end
        endcase
    end

    // output and direction registers; output bits store whatever the
    // direction, the pin only shows them through the enable
    always_ff @(posedge clk) begin
        if (rst) begin
            out_a_r <= PORT_W'(`DPHIO_RST_DATA);
            out_b_r <= PORT_W'(`DPHIO_RST_DATA);
            dir_a_r <= PORT_W'(`DPHIO_RST_DIR);
            dir_b_r <= PORT_W'(`DPHIO_RST_DIR);
            ctrl_r <= `DPHIO_RST_CTRL;
        end else begin
            if (wr_a) begin
                out_a_r <= bus_wdata[PORT_W-1:0];
            end
            if (wr_b) begin
                out_b_r <= bus_wdata[PORT_W-1:0];
            end
            if (wr_dir_a) begin
                dir_a_r <= bus_wdata[PORT_W-1:0];
            end
            if (wr_dir_b) begin
                dir_b_r <= bus_wdata[PORT_W-1:0];
            end
            if (wr_ctrl) begin
                ctrl_r <= bus_wdata;
            end
        end
    end

    // input latches; an edge in the cycle that reads held port A data is not captured, and the latch turns transparent
    always_ff @(posedge clk) begin
        if (rst) begin
            in_a_latch_r <= '0;
            in_b_latch_r <= '0;
            in_a_held_r <= 1'b0;
        end else begin
            if (a1_edge && !in_a_held_r) begin
                in_a_latch_r <= port_a_lines_in;
            end
            if (a1_edge && latch_en_a && !in_a_held_r) begin
                in_a_held_r <= 1'b1;
            end else if (rd_a || !latch_en_a) begin
                in_a_held_r <= 1'b0;
            end
            if (b1_edge) begin
                in_b_latch_r <= port_b_lines_in;
            end
        end
    end

    // edge history, flags and line two drivers
    always_ff @(posedge clk) begin
        if (rst) begin
            a1_prev_r <= 1'b0;
            a2_prev_r <= 1'b0;
            b1_prev_r <= 1'b0;
            b2_prev_r <= 1'b0;
            flags_r <= 4'h0;
            a2_out_r <= 1'b1;
            b2_out_r <= 1'b1;
            a2_pulse_r <= 1'b0;
            b2_pulse_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            a1_prev_r <= port_a_ctrl_line_one;
            a2_prev_r <= port_a_ctrl_line_two_in;
            b1_prev_r <= port_b_ctrl_line_one;
            b2_prev_r <= port_b_ctrl_line_two_in;
            flags_r <= flags_nxt;
            a2_out_r <= a2_out_nxt;
            b2_out_r <= b2_out_nxt;
            // pulse request lasts one cycle, so the low lasts one cycle
            a2_pulse_r <= acc_a_hs && (a2_mode == DPHIO_PULSE);
            b2_pulse_r <= wr_b && (b2_mode == DPHIO_PULSE);
            rdata_r <= rdata_nxt;
        end
    end

    // pins
    assign port_a_lines_out = out_a_r;
    assign port_a_lines_oe = dir_a_r;
    assign port_b_lines_out = out_b_r;
    assign port_b_lines_oe = dir_b_r;
    assign port_a_ctrl_line_two_out = a2_out_r;
    assign port_a_ctrl_line_two_oe = ctrl_r[`DPHIO_CTRL_A2_MSB];
    assign port_b_ctrl_line_two_out = b2_out_r;
    assign port_b_ctrl_line_two_oe = ctrl_r[`DPHIO_CTRL_B2_MSB];
    assign line_flags = flags_r;
    assign bus_rdata = rdata_r;

endmodule

// ===== bench/dphio_assertions.sv
/*
 * port-level assertions for dphio_top.
 * assumes the line control register changes only by host writes.
 */
`timescale 1ns/1ns
module dphio_chk #(
    parameter int PORT_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic [PORT_W-1:0] port_a_lines_in,
    input wire logic [PORT_W-1:0] port_a_lines_oe,
    input wire logic [PORT_W-1:0] port_b_lines_out,
    input wire logic [PORT_W-1:0] port_b_lines_oe,
    input wire logic port_a_ctrl_line_one,
    input wire logic port_a_ctrl_line_two_out,
    input wire logic port_b_ctrl_line_two_out,
    input wire logic port_b_ctrl_line_two_oe,
    input wire logic latch_en_a,
    input wire logic [3:0] line_flags
);
    // shadow of the line control register, rebuilt from host writes
    logic [7:0] ctrl_r;
    logic acc_a;
    logic rd;
    assign acc_a = bus_sel && bus_addr == 4'h1;
    assign rd = bus_sel && !bus_wr;
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= 8'h00;
        end else if (bus_sel && bus_wr && bus_addr == 4'hc) begin
            ctrl_r <= bus_wdata;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    a_dir_oe_load: assert property (bus_sel && bus_wr && bus_addr == 4'h3 |=>
        port_a_lines_oe == $past(bus_wdata[PORT_W-1:0])) else $error("dir a write");
    a_a_read_pins: assert property (rd && bus_addr == 4'h1 && !latch_en_a |=>
        bus_rdata[PORT_W-1:0] == $past(port_a_lines_in)) else $error("port a read");
    a_b_read_out: assert property (rd && bus_addr == 4'h0 |=>
        ((bus_rdata[PORT_W-1:0] ^ $past(port_b_lines_out)) & $past(port_b_lines_oe)) == '0)
        else $error("port b read");
    a_a1_flag_set: assert property ($rose(port_a_ctrl_line_one) && ctrl_r[0] |->
        ##[1:2] line_flags[0]) else $error("a1 flag");
    a_hs_lower: assert property (acc_a && ctrl_r[3:1] == 3'h4 |=>
        !port_a_ctrl_line_two_out) else $error("a2 not lowered");
    a_hs_raise: assert property ($rose(port_a_ctrl_line_one) && ctrl_r[3:0] == 4'h9 && !acc_a
        |-> ##[1:2] port_a_ctrl_line_two_out) else $error("a2 not raised");
    a_pulse_shape: assert property (acc_a && ctrl_r[3:1] == 3'h5 |=>
        port_a_ctrl_line_two_out ##1 !port_a_ctrl_line_two_out ##1 port_a_ctrl_line_two_out)
        else $error("a2 pulse");
    a_b2_oe_mode: assert property (port_b_ctrl_line_two_oe == ctrl_r[7])
        else $error("b2 enable");
    a_b2_const_out: assert property (ctrl_r[7:6] == 2'b11 && $stable(ctrl_r) |->
        port_b_ctrl_line_two_out == ctrl_r[5]) else $error("b2 level");
endmodule

bind dphio_top dphio_chk #(.PORT_W(PORT_W)) u_chk (.*);

// ===== bench/dphio_periph.sv
/*
 * peripheral on the far side of both ports.
 * assumes positive active edges are selected on both line one inputs.
 */
`timescale 1ns/1ns
module dphio_periph (
    input wire logic clk,
    input wire logic [7:0] a_word,
    input wire logic [7:0] b_word,
    input wire logic a_ready,
    input wire logic b_ready,
    input wire logic a2_lvl,
    input wire logic b2_lvl,
    input wire logic [3:0] ack_dly,
    input wire logic [7:0] port_a_lines_out,
    input wire logic [7:0] port_a_lines_oe,
    input wire logic [7:0] port_b_lines_out,
    input wire logic [7:0] port_b_lines_oe,
    input wire logic port_a_ctrl_line_two_out,
    input wire logic port_a_ctrl_line_two_oe,
    input wire logic port_b_ctrl_line_two_out,
    input wire logic port_b_ctrl_line_two_oe,
    output logic [7:0] port_a_lines_in,
    output logic [7:0] port_b_lines_in,
    output logic port_a_ctrl_line_one,
    output logic port_b_ctrl_line_one,
    output logic port_a_ctrl_line_two_in,
    output logic port_b_ctrl_line_two_in
);
    logic [3:0] b_cnt = 4'h0;
    // lines driven by the device are released, so the pin shows the device level
    assign port_a_lines_in = (port_a_lines_oe & port_a_lines_out) | (~port_a_lines_oe & a_word);
    assign port_b_lines_in = (port_b_lines_oe & port_b_lines_out) | (~port_b_lines_oe & b_word);
    assign port_a_ctrl_line_one = a_ready;
    assign port_a_ctrl_line_two_in = port_a_ctrl_line_two_oe ? port_a_ctrl_line_two_out : a2_lvl;
    // undriven b line two shows the level the peripheral puts on it
    assign port_b_ctrl_line_two_in = port_b_ctrl_line_two_oe ? port_b_ctrl_line_two_out : b2_lvl;
    // data taken held until data ready is released; ack_dly sets prompt or slow
    always @(posedge clk) begin
        b_cnt <= (port_b_ctrl_line_two_oe && !port_b_ctrl_line_two_out) ? b_cnt + 4'h1 : 4'h0;
    end
    assign port_b_ctrl_line_one = b_ready || b_cnt > ack_dly;
endmodule

// ===== bench/tb_dual_port_handshake_io.sv
/*
 * self-checking bench for dphio_top with a peripheral model.
 * assumes a 250 MHz clock and inputs driven 1 ns after each rising edge.
 */
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin \
        num_checks++; \
        if ((got) !== (ex)) begin \
            error_cnt++; \
            $display("ERROR %s expected %h seen %h", nm, ex, got); \
        end \
    end
module tb_dual_port_handshake_io;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic bus_sel, bus_wr, latch_en_a, latch_en_b, a_ready, b_ready, a2_lvl, b2_lvl;
    logic [3:0] bus_addr, flag_clr, line_flags, ack_dly;
    logic [7:0] bus_wdata, bus_rdata, a_word, b_word, exp_v, dm, om;
    logic [7:0] port_a_lines_in, port_a_lines_out, port_a_lines_oe;
    logic [7:0] port_b_lines_in, port_b_lines_out, port_b_lines_oe;
    logic port_a_ctrl_line_one, port_a_ctrl_line_two_in, port_a_ctrl_line_two_out;
    logic port_a_ctrl_line_two_oe, port_b_ctrl_line_one, port_b_ctrl_line_two_in;
    logic port_b_ctrl_line_two_out, port_b_ctrl_line_two_oe;
    logic rd_d = 1'b0;
    logic [31:0] seed = 32'h000145e8;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [7:0] exp_q[$];

    dphio_top dut (.*);
    dphio_periph u_periph (.*);

    always #2 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // one access per call; bus_sel stays up so back-to-back calls never re-raise it
    task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       input logic [7:0] e);
        bus_sel = 1'b1;
        bus_wr = wr;
        bus_addr = a;
        bus_wdata = d;
        if (!wr) begin
            exp_q.push_back(e);
        end
        @(posedge clk);
        #1;
    endtask

    task automatic idle(input int n);
        bus_sel = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // read data lands one edge after the access; compare mid-cycle
    always @(posedge clk) rd_d <= bus_sel && !bus_wr;
    always @(negedge clk) begin
        if (rd_d) begin
            exp_v = exp_q.pop_front();
            `CHK("bus_rdata", exp_v, bus_rdata)
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        {bus_sel, bus_wr, latch_en_a, latch_en_b, a_ready, b_ready} = 6'h00;
        {b2_lvl, a2_lvl, bus_addr, flag_clr, ack_dly} = 14'h3000;
        {bus_wdata, a_word, b_word} = 24'h000000;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        acc(1'b0, 4'h2, 8'h00, 8'h00);
        acc(1'b0, 4'hc, 8'h00, 8'h00);
        acc(1'b0, 4'h5, 8'h00, 8'h00);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            dm = seed[7:0];
            om = seed[15:8];
            acc(1'b1, 4'h3, dm, 8'h00);
            acc(1'b1, 4'h1, om, 8'h00);
            acc(1'b1, 4'h2, dm, 8'h00);
            acc(1'b1, 4'h0, om, 8'h00);
            a_word = seed[23:16];
            b_word = seed[31:24];
            acc(1'b0, 4'h1, 8'h00, (dm & om) | (~dm & a_word));
            acc(1'b0, 4'h0, 8'h00, (dm & om) | (~dm & b_word));
            `CHK("port_a_lines_oe", dm, port_a_lines_oe)
            `CHK("port_b_lines_out", om, port_b_lines_out)
            `CHK("port_b_lines_oe", dm, port_b_lines_oe)
            `CHK("port_a_lines_out", om, port_a_lines_out)
        end
        acc(1'b1, 4'h3, 8'h00, 8'h00);
        acc(1'b1, 4'h2, 8'h00, 8'h00);
        acc(1'b1, 4'hc, 8'h11, 8'h00);
        idle(2);
        {latch_en_a, latch_en_b, a_word, b_word} = 18'h33cc3;
        {a_ready, b_ready} = 2'h3;
        idle(2);
        {a_ready, b_ready, a_word, b_word} = 18'h055aa;
        idle(2);
        `CHK("line_flags", 4'h5, line_flags)
        acc(1'b0, 4'h1, 8'h00, 8'h3c);
        acc(1'b0, 4'h1, 8'h00, 8'h55);
        acc(1'b0, 4'h0, 8'h00, 8'hc3);
        idle(1);
        `CHK("line_flags", 4'h0, line_flags)
        {latch_en_a, latch_en_b} = 2'h0;
        for (int m = 0; m < 8; m++) begin
            acc(1'b1, 4'hc, {m[2:0], 1'b1, m[2:0], 1'b1}, 8'h00);
            idle(3);
            `CHK("a2_oe", m[2], port_a_ctrl_line_two_oe)
            `CHK("b2_oe", m[2], port_b_ctrl_line_two_oe)
            if (m != 4 && m != 5) begin
                `CHK("a2_out", m[2] ? m[0] : 1'b1, port_a_ctrl_line_two_out)
                `CHK("b2_out", m[2] ? m[0] : 1'b1, port_b_ctrl_line_two_out)
            end
            if (m == 5) begin
                acc(1'b1, 4'h1, 8'h00, 8'h00);
                acc(1'b1, 4'h0, 8'h00, 8'h00);
                `CHK("a2_out", 1'b0, port_a_ctrl_line_two_out)
                idle(1);
                `CHK("a2_out", 1'b1, port_a_ctrl_line_two_out)
                `CHK("b2_out", 1'b0, port_b_ctrl_line_two_out)
                idle(2);
                `CHK("b2_out", 1'b1, port_b_ctrl_line_two_out)
            end
            if (m == 4) begin
                acc(1'b0, 4'h1, 8'h00, 8'h55);
                idle(1);
                `CHK("a2_out", 1'b0, port_a_ctrl_line_two_out)
                a_ready = 1'b1;
                idle(3);
                `CHK("a2_out", 1'b1, port_a_ctrl_line_two_out)
                a_ready = 1'b0;
                acc(1'b0, 4'h0, 8'h00, 8'haa);
                idle(1);
                `CHK("b2_out", 1'b1, port_b_ctrl_line_two_out)
                for (int d = 8; d >= 0; d -= 8) begin
                    ack_dly = d[3:0];
                    acc(1'b1, 4'h0, 8'h5a, 8'h00);
                    idle(2);
                    if (d != 0) begin
                        `CHK("b2_out", 1'b0, port_b_ctrl_line_two_out)
                    end
                    idle(14);
                    `CHK("b2_out", 1'b1, port_b_ctrl_line_two_out)
                    `CHK("b1_flag", 1'b1, line_flags[2])
                    flag_clr = 4'h4;
                    idle(1);
                    flag_clr = 4'h0;
                end
            end
        end
        acc(1'b1, 4'hc, 8'h22, 8'h00);
        idle(2);
        {a2_lvl, b2_lvl} = 2'h0;
        idle(3);
        acc(1'b0, 4'h1, 8'h00, 8'h55);
        acc(1'b0, 4'h0, 8'h00, 8'haa);
        idle(2);
        `CHK("a2_flag", 1'b1, line_flags[1])
        `CHK("b2_flag", 1'b1, line_flags[3])
        flag_clr = 4'ha;
        idle(1);
        flag_clr = 4'h0;
        acc(1'b1, 4'hc, 8'h00, 8'h00);
        {a2_lvl, b2_lvl} = 2'h3;
        idle(2);
        `CHK("a2_flag", 1'b0, line_flags[1])
        `CHK("b2_flag", 1'b0, line_flags[3])
        {a2_lvl, b2_lvl} = 2'h0;
        idle(3);
        `CHK("b2_flag", 1'b1, line_flags[3])
        acc(1'b0, 4'h1, 8'h00, 8'h55);
        acc(1'b0, 4'h0, 8'h00, 8'haa);
        idle(1);
        `CHK("a2_flag", 1'b0, line_flags[1])
        `CHK("b2_flag", 1'b0, line_flags[3])
        idle(4);
        complete_run();
    end
endmodule
